// >>> verilog/dir_pkg.sv
// Notes on behaviour
// - summary bit 0 flags module failure
// - summary bit 2 flags external error
// - summary bit 3 flags any channel error
// - module info bits 3..0 read 1111b
// - module info bit 4 set, reads 1fh
// - extended bit 3 flags buffer overflow
// - extended bit 6 flags lost process interrupt
// - diagnostic bits per channel reads 00h
// - channel count reads 02h
// - channel fault bits 0,1 flag lost edges
// - record latches full ticker at capture
// - 32-bit microsecond ticker starts at zero
// - ticker wraps to zero after maximum
// - going event follows when causes vanish
// - events between incoming and going discarded
// - serve full set 01h and short set 00h
`default_nettype none
package dir_pkg;
    // clock and ticker timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int PRE_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRE_W = 7;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRE_CYCLES - 1);
    localparam int TS_W = 32;
    localparam logic [TS_W-1:0] TS_RESET = 32'h0000_0000;
    localparam logic [TS_W-1:0] TS_MAX = 32'hffff_ffff;
    // record set codes and lengths in bytes
    localparam logic [7:0] SET_SHORT = 8'h00;
    localparam logic [7:0] SET_FULL = 8'h01;
    localparam int IDX_W = 5;
    localparam logic [IDX_W-1:0] LEN_SHORT = 5'h04;
    localparam logic [IDX_W-1:0] LEN_FULL = 5'h14;
    // byte positions in the record
    localparam logic [IDX_W-1:0] IDX_SUMMARY = 5'h00;
    localparam logic [IDX_W-1:0] IDX_MOD_INFO = 5'h01;
    localparam logic [IDX_W-1:0] IDX_SPARE_C = 5'h02;
    localparam logic [IDX_W-1:0] IDX_EXTENDED = 5'h03;
    localparam logic [IDX_W-1:0] IDX_CH_KIND = 5'h04;
    localparam logic [IDX_W-1:0] IDX_BITS_PER_CH = 5'h05;
    localparam logic [IDX_W-1:0] IDX_CH_COUNT = 5'h06;
    localparam logic [IDX_W-1:0] IDX_CH_FAULT = 5'h07;
    localparam logic [IDX_W-1:0] IDX_TS0 = 5'h10;
    localparam logic [IDX_W-1:0] IDX_TS1 = 5'h11;
    localparam logic [IDX_W-1:0] IDX_TS2 = 5'h12;
    localparam logic [IDX_W-1:0] IDX_TS3 = 5'h13;
    // field positions
    localparam int SUM_FAIL_BIT = 0;
    localparam int SUM_EXT_BIT = 2;
    localparam int SUM_CHAN_BIT = 3;
    localparam int EXT_OVF_BIT = 3;
    localparam int EXT_IRQ_LOST_BIT = 6;
    localparam int CH_N = 2;
    // reset and constant values
    localparam logic [7:0] SUMMARY_RESET = 8'h00;
    localparam logic [7:0] EXTENDED_RESET = 8'h00;
    localparam logic [7:0] CH_FAULT_RESET = 8'h00;
    localparam logic [7:0] SPARE_VALUE = 8'h00;
    localparam logic [7:0] MOD_INFO_VALUE = 8'h1f;
    localparam logic [7:0] CH_KIND_VALUE = 8'h70;
    localparam logic [7:0] BITS_PER_CH_VALUE = 8'h00;
    localparam logic [7:0] CH_COUNT_VALUE = 8'h02;
    // diagnostic sequencer states
    typedef enum logic [1:0] {
        DIR_IDLE = 2'b01,
        DIR_ACTIVE = 2'b10
    } dir_state_t;
endpackage : dir_pkg
`default_nettype wire

// >>> verilog/dir_us_ticker.sv
`timescale 1ns/1ps
`default_nettype none
module dir_us_ticker (
    input wire logic core_clk,
    input wire logic rst_b,
    output logic [dir_pkg::TS_W-1:0] us_count
);
    import dir_pkg::*;

    logic [PRE_W-1:0] pre_reg; // cycles within the current microsecond
    logic [TS_W-1:0] us_reg; // free running microsecond count
    logic tick; // last cycle of a microsecond

    assign tick = (pre_reg == PRE_LAST);
    assign us_count = us_reg;

    // prescaler divides the module clock down to one microsecond
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pre_reg <= '0;
        end else if (tick) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 1'b1;
        end
    end

    // microsecond count, natural 32-bit overflow gives the wrap
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            us_reg <= TS_RESET;
        end else if (tick) begin
            us_reg <= us_reg + 1'b1;
        end
    end

    property p_tick_step;
        @(posedge core_clk) disable iff (!rst_b)
        tick && us_reg != TS_MAX |=> us_reg == $past(us_reg) + 1'b1;
    endproperty
    a_tick_step: assert property (p_tick_step) else $error("ticker missed a step");

    property p_tick_wrap;
        @(posedge core_clk) disable iff (!rst_b)
        tick && us_reg == TS_MAX |=> us_reg == TS_RESET;
    endproperty
    a_tick_wrap: assert property (p_tick_wrap) else $error("ticker did not wrap");

    property p_tick_hold;
        @(posedge core_clk) disable iff (!rst_b)
        !tick |=> $stable(us_reg);
    endproperty
    a_tick_hold: assert property (p_tick_hold) else $error("ticker moved early");

    property p_tick_zero;
        @(posedge core_clk) !rst_b |=> us_reg == TS_RESET;
    endproperty
    a_tick_zero: assert property (p_tick_zero) else $error("ticker not zero");
endmodule : dir_us_ticker
`default_nettype wire

// >>> verilog/dir_record.sv
`timescale 1ns/1ps
`default_nettype none
module dir_record (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic module_fail,
    input wire logic ext_error,
    input wire logic buf_overflow,
    input wire logic irq_lost,
    input wire logic [dir_pkg::CH_N-1:0] edge_lost,
    input wire logic rd_req,
    input wire logic [7:0] record_set_selector,
    input wire logic [dir_pkg::IDX_W-1:0] rd_idx,
    output logic rd_ack,
    output logic [7:0] rd_data,
    output logic rd_err,
    output logic diag_incoming,
    output logic diag_going,
    output logic diag_active
);
    import dir_pkg::*;

    dir_state_t state_reg; // diagnostic sequencer
    dir_state_t state_next;
    logic [7:0] summary_reg; // summary byte snapshot
    logic [7:0] extended_reg; // extended byte snapshot
    logic [7:0] ch_fault_reg; // channel fault byte snapshot
    logic [TS_W-1:0] ts_reg; // ticker value at capture
    logic [TS_W-1:0] us_now; // live ticker
    logic cause; // any diagnostic cause present
    logic capture; // record refresh this cycle
    logic rd_ack_reg;
    logic [7:0] rd_data_reg;
    logic rd_err_reg;
    logic incoming_reg;
    logic going_reg;

    // true when the byte lies inside the selected record set
    function automatic logic idx_ok(input logic [7:0] set, input logic [IDX_W-1:0] idx);
        logic ok;
        ok = 1'b0;
        if (set == SET_FULL) begin
            ok = (idx < LEN_FULL);
        end else if (set == SET_SHORT) begin
            ok = (idx < LEN_SHORT);
        end
        return ok;
    endfunction : idx_ok

    // picks one byte of the record, spare bytes read zero
    function automatic logic [7:0] rec_byte(
        input logic [IDX_W-1:0] idx,
        input logic [7:0] sum,
        input logic [7:0] ext,
        input logic [7:0] chf,
        input logic [TS_W-1:0] ts
    );
        logic [7:0] b;
        b = SPARE_VALUE;
        unique case (idx)
            IDX_SUMMARY: b = sum;
            IDX_MOD_INFO: b = MOD_INFO_VALUE;
            IDX_SPARE_C: b = SPARE_VALUE;
            IDX_EXTENDED: b = ext;
            IDX_CH_KIND: b = CH_KIND_VALUE;
            IDX_BITS_PER_CH: b = BITS_PER_CH_VALUE;
            IDX_CH_COUNT: b = CH_COUNT_VALUE;
            IDX_CH_FAULT: b = chf;
            // most significant byte first
            IDX_TS0: b = ts[31:24];
            IDX_TS1: b = ts[23:16];
            IDX_TS2: b = ts[15:8];
            IDX_TS3: b = ts[7:0];
            default: b = SPARE_VALUE; // per-channel spares read zero
        endcase
        return b;
    endfunction : rec_byte

    dir_us_ticker u_ticker (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .us_count(us_now)
    );

    assign cause = module_fail | ext_error | buf_overflow | irq_lost | (|edge_lost);
    // refresh only on the incoming and going transitions
    assign capture = (state_reg == DIR_IDLE && cause) || (state_reg == DIR_ACTIVE && !cause);

    // next state: leave active only once every cause is gone
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DIR_IDLE: begin
                if (cause) begin
                    state_next = DIR_ACTIVE;
                end
            end
            DIR_ACTIVE: begin
                if (!cause) begin
                    state_next = DIR_IDLE;
                end
            end
            default: state_next = DIR_IDLE; // illegal code recovers
        endcase
    end

    // sequencer register
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg <= DIR_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // incoming and going pulses, one cycle each
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            incoming_reg <= 1'b0;
            going_reg <= 1'b0;
        end else begin
            incoming_reg <= (state_reg == DIR_IDLE) && cause;
            going_reg <= (state_reg == DIR_ACTIVE) && !cause;
        end
    end

    // summary byte; frozen while active, so late events are dropped
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            summary_reg <= SUMMARY_RESET;
        end else if (capture) begin
            summary_reg <= SUMMARY_RESET;
            summary_reg[SUM_FAIL_BIT] <= module_fail;
            summary_reg[SUM_EXT_BIT] <= ext_error;
            summary_reg[SUM_CHAN_BIT] <= |edge_lost;
        end
    end

    // extended byte
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            extended_reg <= EXTENDED_RESET;
        end else if (capture) begin
            extended_reg <= EXTENDED_RESET;
            extended_reg[EXT_OVF_BIT] <= buf_overflow;
            extended_reg[EXT_IRQ_LOST_BIT] <= irq_lost;
        end
    end

    // channel fault byte, only at the two transitions
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ch_fault_reg <= CH_FAULT_RESET;
        end else if (capture) begin
            ch_fault_reg <= {{(8 - CH_N){1'b0}}, edge_lost};
        end
    end

    // timestamp of the recorded event
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ts_reg <= TS_RESET;
        end else if (capture) begin
            ts_reg <= us_now;
        end
    end

    // record read port, answer one cycle after the request
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rd_ack_reg <= 1'b0;
            rd_data_reg <= SPARE_VALUE;
            rd_err_reg <= 1'b0;
        end else begin
            rd_ack_reg <= rd_req;
            if (rd_req && idx_ok(record_set_selector, rd_idx)) begin
                rd_data_reg <= rec_byte(rd_idx, summary_reg, extended_reg,
                                        ch_fault_reg, ts_reg);
                rd_err_reg <= 1'b0;
            end else if (rd_req) begin
                // unknown set or byte past its end reads zero
                rd_data_reg <= SPARE_VALUE;
                rd_err_reg <= 1'b1;
            end
        end
    end

    assign rd_ack = rd_ack_reg;
    assign rd_data = rd_data_reg;
    assign rd_err = rd_err_reg;
    assign diag_incoming = incoming_reg;
    assign diag_going = going_reg;
    assign diag_active = (state_reg == DIR_ACTIVE);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_fail_bit;
        capture |=> summary_reg[SUM_FAIL_BIT] == $past(module_fail);
    endproperty
    a_fail_bit: assert property (p_fail_bit) else $error("fail bit wrong");

    property p_ext_bit;
        capture |=> summary_reg[SUM_EXT_BIT] == $past(ext_error);
    endproperty
    a_ext_bit: assert property (p_ext_bit) else $error("external bit wrong");

    property p_chan_bit;
        summary_reg[SUM_CHAN_BIT] == (ch_fault_reg != CH_FAULT_RESET);
    endproperty
    a_chan_bit: assert property (p_chan_bit) else $error("channel bit wrong");

    property p_sum_rsvd;
        summary_reg[7:4] == 4'h0 && !summary_reg[1];
    endproperty
    a_sum_rsvd: assert property (p_sum_rsvd) else $error("summary reserved set");

    sequence s_read(logic [IDX_W-1:0] i);
        rd_req && record_set_selector == SET_FULL && rd_idx == i;
    endsequence

    property p_mod_info;
        s_read(IDX_MOD_INFO) |=> rd_ack && rd_data == 8'h1f && !rd_err;
    endproperty
    a_mod_info: assert property (p_mod_info) else $error("module info wrong");

    property p_ch_kind;
        s_read(IDX_CH_KIND) |=> rd_data == 8'h70;
    endproperty
    a_ch_kind: assert property (p_ch_kind) else $error("channel kind wrong");

    property p_counts;
        s_read(IDX_CH_COUNT) |=> rd_data == 8'h02;
    endproperty
    a_counts: assert property (p_counts) else $error("channel count wrong");

    property p_bits_per_ch;
        s_read(IDX_BITS_PER_CH) |=> rd_data == 8'h00;
    endproperty
    a_bits_per_ch: assert property (p_bits_per_ch) else $error("bits per channel wrong");

    property p_ext_byte;
        capture |=> extended_reg[EXT_OVF_BIT] == $past(buf_overflow)
            && extended_reg[EXT_IRQ_LOST_BIT] == $past(irq_lost);
    endproperty
    a_ext_byte: assert property (p_ext_byte) else $error("extended byte wrong");

    property p_edge_flags;
        capture |=> ch_fault_reg == {6'h00, $past(edge_lost)};
    endproperty
    a_edge_flags: assert property (p_edge_flags) else $error("edge flags wrong");

    property p_stamp;
        capture |=> ts_reg == $past(us_now);
    endproperty
    a_stamp: assert property (p_stamp) else $error("timestamp not latched");

    sequence s_causes_gone;
        diag_active && !cause;
    endsequence

    property p_going;
        s_causes_gone |=> diag_going && !diag_active ##1 !diag_going;
    endproperty
    a_going: assert property (p_going) else $error("going event missing");

    property p_discard;
        diag_active && cause |=> $stable(ch_fault_reg) && $stable(ts_reg);
    endproperty
    a_discard: assert property (p_discard) else $error("event stored while active");

    property p_short_set;
        rd_req && record_set_selector == SET_SHORT && rd_idx >= LEN_SHORT
            |=> rd_ack && rd_err && rd_data == 8'h00;
    endproperty
    a_short_set: assert property (p_short_set) else $error("short set overrun");

    // every taken request is answered on the very next edge
    property p_ack_one;
        rd_req |=> rd_ack;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("read not answered");

    // no answer without a request, so the acknowledge is a pulse
    property p_ack_pulse;
        !rd_req |=> !rd_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("stray read answer");

    // a set code other than short or full is refused with zero data
    property p_bad_set;
        rd_req && record_set_selector != SET_FULL && record_set_selector != SET_SHORT
            |=> rd_ack && rd_err && rd_data == 8'h00;
    endproperty
    a_bad_set: assert property (p_bad_set) else $error("unknown set accepted");

    // reserved bits of the stored bytes never report anything
    property p_rsvd_bits;
        extended_reg[7] == 1'b0 && extended_reg[5:4] == 2'h0 && extended_reg[2:0] == 3'h0
            && ch_fault_reg[7:CH_N] == '0;
    endproperty
    a_rsvd_bits: assert property (p_rsvd_bits) else $error("reserved bit set");

    // a first cause while idle opens the record window
    sequence s_cause_arrives;
        !diag_active && cause;
    endsequence

    property p_incoming;
        s_cause_arrives |=> diag_incoming && diag_active ##1 !diag_incoming;
    endproperty
    a_incoming: assert property (p_incoming) else $error("incoming event missing");
endmodule : dir_record
`default_nettype wire

// >>> dv/dir_head_model.sv
`timescale 1ns/1ps
`default_nettype none
// head station reading record bytes over the backplane port
module dir_head_model (
    input wire logic core_clk,
    input wire logic rd_ack,
    input wire logic [7:0] rd_data,
    input wire logic rd_err,
    output logic rd_req,
    output logic [7:0] record_set_selector,
    output logic [dir_pkg::IDX_W-1:0] rd_idx
);
    import dir_pkg::*;

    // idle port at time zero
    initial begin
        rd_req = 1'b0;
        record_set_selector = 8'h01;
        rd_idx = '0;
    end

    // one request cycle, then bounded wait for the answer
    task automatic read_byte(input logic [7:0] set, input logic [IDX_W-1:0] idx,
                             output logic [7:0] data, output logic err, output logic ok);
        int n;
        @(negedge core_clk);
        rd_req = 1'b1;
        record_set_selector = set;
        rd_idx = idx;
        @(negedge core_clk);
        rd_req = 1'b0;
        // released qualifiers show the inverse, never the stale value
        record_set_selector = ~set;
        rd_idx = ~idx;
        n = 0;
        while (rd_ack !== 1'b1 && n < 4) begin
            @(negedge core_clk);
            n++;
        end
        ok = (rd_ack === 1'b1);
        data = rd_data;
        err = rd_err;
    endtask : read_byte
endmodule : dir_head_model
`default_nettype wire

// >>> dv/dir_record_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dir_record_tb_top;
    import dir_pkg::*;
    logic core_clk, rst_b, module_fail, ext_error, buf_overflow, irq_lost;
    logic [CH_N-1:0] edge_lost;
    logic rd_req, rd_ack, rd_err, diag_incoming, diag_going, diag_active;
    logic [7:0] record_set_selector, rd_data;
    logic [IDX_W-1:0] rd_idx;
    int miscompares, n_tests, cyc, seed, t0, t1, i, k;
    int exp_rec[20]; // model of the record bytes
    logic [5:0] v; // cause vector: edge[5:4] irq ovf ext fail
    logic [7:0] d;
    logic e, ok;

    dir_record dut (.core_clk(core_clk), .rst_b(rst_b), .module_fail(module_fail),
        .ext_error(ext_error), .buf_overflow(buf_overflow), .irq_lost(irq_lost),
        .edge_lost(edge_lost), .rd_req(rd_req), .record_set_selector(record_set_selector),
        .rd_idx(rd_idx), .rd_ack(rd_ack), .rd_data(rd_data), .rd_err(rd_err),
        .diag_incoming(diag_incoming), .diag_going(diag_going), .diag_active(diag_active));
    dir_head_model u_head (.core_clk(core_clk), .rd_ack(rd_ack), .rd_data(rd_data),
        .rd_err(rd_err), .rd_req(rd_req), .record_set_selector(record_set_selector),
        .rd_idx(rd_idx));

    // 100 mhz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // cycle count doubles as hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc >= 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // expected record from a cause snapshot and a ticker value
    task automatic build(input logic [5:0] c, input int ts);
        for (int j = 0; j < 20; j++) exp_rec[j] = 0;
        exp_rec[0] = c[0] | (c[1] << 2) | ((c[5] | c[4]) << 3);
        exp_rec[1] = 31;
        exp_rec[3] = (c[2] << 3) | (c[3] << 6);
        exp_rec[4] = 112;
        exp_rec[6] = 2;
        exp_rec[7] = c[5:4];
        // most significant byte first
        for (int j = 0; j < 4; j++) exp_rec[16 + j] = (ts >> (24 - 8 * j)) & 255;
    endtask : build

    // full-set read of one byte against the model
    task automatic rd_chk(input int idx);
        u_head.read_byte(8'h01, idx[IDX_W-1:0], d, e, ok);
        chk(ok, 1'b1);
        chk(e, 1'b0);
        chk(d, exp_rec[idx]);
    endtask : rd_chk

    // refused request: error flag and zero data
    task automatic rd_bad(input logic [7:0] set, input logic [IDX_W-1:0] idx);
        u_head.read_byte(set, idx, d, e, ok);
        chk({ok, e, d}, {2'b11, 8'h00});
    endtask : rd_bad

    // drive causes at a falling edge and watch the capture pulse
    task automatic apply(input logic [5:0] c, input logic going);
        {edge_lost, irq_lost, buf_overflow, ext_error, module_fail} = c;
        @(negedge core_clk);
        chk({diag_incoming, diag_going, diag_active}, {~going, going, ~going});
        @(negedge core_clk);
        chk({diag_incoming, diag_going}, 2'b00);
    endtask : apply

    initial begin
        rst_b = 1'b0;
        {edge_lost, irq_lost, buf_overflow, ext_error, module_fail} = '0;
        miscompares = 0;
        n_tests = 0;
        seed = 32'ha2fa;
        repeat (16) @(negedge core_clk);
        rst_b = 1'b1;
        // first capture before the ticker's first step: timestamp zero
        t0 = cyc;
        apply(6'h01, 1'b0);
        build(6'h01, 0);
        for (i = 0; i < 20; i++) rd_chk(i);
        for (i = 0; i < 4; i++) begin
            u_head.read_byte(8'h00, i[IDX_W-1:0], d, e, ok);
            chk({ok, e, d}, {2'b10, 8'(exp_rec[i])});
        end
        rd_bad(8'h00, 5'h04);
        rd_bad(8'h01, 5'h14);
        rd_bad(8'h01, 5'h1f);
        rd_bad(8'h02, 5'h00);
        // causes changing while active leave the record frozen
        for (i = 0; i < 4; i++) begin
            v = 6'($random(seed)) | 6'h02;
            {edge_lost, irq_lost, buf_overflow, ext_error, module_fail} = v;
            rd_chk(0);
            rd_chk(3);
            rd_chk(7);
            chk(diag_incoming, 1'b0);
        end
        // going capture exactly 1000 cycles after incoming: ten ticks
        while (cyc - t0 < 1000) @(negedge core_clk);
        apply(6'h00, 1'b1);
        build(6'h00, 10);
        for (i = 0; i < 20; i++) rd_chk(i);
        // random cause sets, incoming a few reads after each going
        for (k = 0; k < 8; k++) begin
            v = 6'($random(seed));
            if (v == 6'h00) v = 6'h30;
            // ticker value at the coming capture edge, 100 cycles a step
            t1 = (cyc - t0) / 100;
            apply(v, 1'b0);
            build(v, t1);
            for (i = 0; i < 20; i++) rd_chk(i);
            t1 = (cyc - t0) / 100;
            apply(6'h00, 1'b1);
            build(6'h00, t1);
            rd_chk(0);
            rd_chk(3);
            rd_chk(7);
            rd_chk(19);
        end
        end_of_test();
    end
endmodule : dir_record_tb_top
`default_nettype wire
